// ==== verilog/pwr_core.sv ====
/*
 privilege modes, windowed register file, access checking, chip selects,
 wait states, same-page detection and timer of a 32-bit integer core.
 assumes instruction decode presents one operation per cycle on plain ports;
 all inputs come from logic on ref_clk.
*/
// Notes on behaviour
// [RL1] privileged op in user mode traps instead
// [RL2] supervisor mode after reset
// [RL3] user to supervisor only on reset/interrupt/trap
// [RL4] access carries 4-bit space, 26-bit word address
// [RL5] user spaces open always, others supervisor only
// [RL6] only loads/stores access bus, four widths
// [RL7] every register 32 bits wide
// [RL8] 104 registers: 8 globals, 6x16 windows
// [RL9] locals private, outs/ins shared with neighbours
// [RL10] 32 registers visible through window pointer
// [RL11] save decrements, restore increments, no data moved
// [RL12] trap or interrupt decrements window pointer
// [RL13] save or restore landing on masked window raises trap
// [RL14] user sees only general and multiply registers
// [RL15] system registers only via privileged alternate access
// [RL16] single-vector mode sends traps to one address
// [RL17] same-page compares masked space and address bits
// [RL18] chip select n on masked range match
// [RL19] chip select 0 on lowest supervisor instruction range
// [RL20] internal ready after per-range wait count
// [RL21] timer reloads from preload on overflow
// [RL22] control register enables each support function
// [RL23] privilege flag 1 supervisor, 0 user
// [RL24] trap return restores previous privilege flag
// [RL25] window pointer wraps modulo six
`timescale 1ns/100ps
`include "pwr_defs.svh"
module pwr_core
   import pwr_pkg::*;
#(
   parameter int NWIN  = `PWR_NWIN,
   parameter int XLEN  = `PWR_XLEN,
   parameter int ADR_W = `PWR_ADR_W
) (
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   input  wire pwr_op_t               op,
   input  wire logic                  op_priv,
   input  wire logic                  irq,
   input  wire logic                  wr_psr_user,
   input  wire logic [2:0]            wr_cwp,
   input  wire logic                  wr_cwp_en,
   input  wire logic [NWIN-1:0]       wim_wdata,
   input  wire logic                  wim_we,
   input  wire logic                  single_vec_wdata,
   input  wire logic                  single_vec_we,
   input  wire logic                  rf_we,
   input  wire logic [4:0]            rf_waddr,
   input  wire logic [XLEN-1:0]       rf_wdata,
   input  wire logic [4:0]            rf_raddr,
   input  wire logic                  y_we,
   input  wire logic [XLEN-1:0]       y_wdata,
   input  wire logic                  acc_req,
   input  wire logic                  acc_is_mem,
   input  wire logic                  acc_write,
   input  wire pwr_width_t            acc_width,
   input  wire logic [3:0]            acc_space,
   input  wire logic [ADR_W-1:0]      acc_addr,
   input  wire logic [3:0]            sscr_wdata,
   input  wire logic                  sscr_we,
   input  wire logic [ADR_W+3:0]      samepg_mask,
   input  wire logic [5*ADR_W-1:0]    range_vals,
   input  wire logic [6*ADR_W-1:0]    range_masks,
   input  wire logic [3*4-1:0]        wait_counts,
   input  wire logic [XLEN-1:0]       timer_preload,
   output      logic                  supervisor,
   output      logic [2:0]            current_window_pointer,
   output      logic [NWIN-1:0]       window_invalid_mask,
   output      logic                  trap_taken,
   output      logic [XLEN-1:0]       trap_target,
   output      logic [XLEN-1:0]       rf_rdata,
   output      logic [XLEN-1:0]       y_reg,
   output      logic                  bus_start,
   output      logic                  bus_write,
   output      logic [1:0]            bus_width,
   output      logic [3:0]            bus_space,
   output      logic [ADR_W-1:0]      bus_addr,
   output      logic                  bus_ready,
   output      logic [5:0]            chip_sel_n,
   output      logic                  same_page_n,
   output      logic [XLEN-1:0]       timer_count,
   output      logic                  timer_ovf
);
   // state
   logic              s_r, s_nxt, ps_r, ps_nxt;
   logic [2:0]        cwp_r, cwp_nxt;
   logic [NWIN-1:0]   wim_r, wim_nxt;
   logic              sv_r, sv_nxt;
   logic [3:0]        sscr_r, sscr_nxt;
   logic              trap_r, trap_nxt;
   logic [XLEN-1:0]   tgt_r, tgt_nxt;
   logic [XLEN-1:0]   y_r, y_nxt;
   logic [XLEN-1:0]   rdata_r, rdata_nxt;
   logic [XLEN-1:0]   rf_r [`PWR_NPHYS]; // RL7 RL8
   logic [6:0]        rf_widx;
   logic [6:0]        rf_ridx;
   logic              start_r, start_nxt, bwr_r, bwr_nxt;
   logic [1:0]        bw_r, bw_nxt;
   logic [3:0]        bsp_r, bsp_nxt;
   logic [ADR_W-1:0]  badr_r, badr_nxt;
   logic              rdy_r, rdy_nxt;
   logic [5:0]        cs_r, cs_nxt;
   logic              sp_r, sp_nxt;
   logic [ADR_W+3:0]  prev_r, prev_nxt;
   pwr_bus_st_t       bst_r, bst_nxt;
   logic [3:0]        wcnt_r, wcnt_nxt;
   logic [5:1]        cs_hit;
   logic [2:0]        cwp_dec, cwp_inc;
   logic              acc_ok;

   // window wrap, kept modulo the window count
   assign cwp_dec = (cwp_r == 3'd0) ? 3'(NWIN - 1) : cwp_r - 3'd1; // RL25
   assign cwp_inc = (cwp_r == 3'(NWIN - 1)) ? 3'd0 : cwp_r + 3'd1; // RL25

   // user space pair open to both modes
   assign acc_ok = s_r || acc_space == `PWR_ASI_UINSTR || acc_space == `PWR_ASI_UDATA; // RL5

   // physical index: globals at 0..7, window w keeps locals then ins at 8+16w;
   // its outs are the ins of window w-1, so a save hands them over unmoved
   function automatic logic [6:0] phys_idx(input logic [4:0] a, input logic [2:0] w);
      logic [7:0] off;
      off = 8'd8 + 8'(w) * 8'd16 + 8'(a) - 8'd16;
      if (off < 8'd8) off = off + 8'(16 * NWIN);
      phys_idx = (a < 5'd8) ? 7'(a) : 7'(off); // RL9 RL10
   endfunction
   assign rf_widx = phys_idx(rf_waddr, cwp_r);
   assign rf_ridx = phys_idx(rf_raddr, cwp_r);

   pwr_cs_if cs_bus ();
   genvar gi;
   generate
      for (gi = 1; gi <= 5; gi++) begin : g_cs
         pwr_cs_cmp #(.ADR_W(ADR_W)) u_cmp (
            .acc        (cs_bus),
            .range_val  (range_vals[(gi-1)*ADR_W +: ADR_W]),
            .range_mask (range_masks[gi*ADR_W +: ADR_W]),
            .hit        (cs_hit[gi])
         );
      end
   endgenerate
   assign cs_bus.addr  = acc_addr;
   assign cs_bus.space = acc_space;
   assign cs_bus.valid = acc_req && acc_is_mem && acc_ok;

   pwr_timer #(.W(XLEN)) u_timer (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .enable  (sscr_r[`PWR_SSCR_TIMER]), // RL22
      .preload (timer_preload),
      .count   (timer_count),
      .ovf     (timer_ovf)
   );

   // control: mode, window pointer, traps
   always_comb begin
      logic do_trap;
      do_trap  = 1'b0;
      s_nxt    = s_r;
      ps_nxt   = ps_r;
      cwp_nxt  = cwp_r;
      wim_nxt  = wim_r;
      sv_nxt   = sv_r;
      sscr_nxt = sscr_r;
      y_nxt    = y_r;
      tgt_nxt  = tgt_r;
      // privileged writes only honoured in supervisor mode
      if (s_r) begin
         if (wim_we)        wim_nxt  = wim_wdata;
         if (single_vec_we) sv_nxt   = single_vec_wdata;
         if (sscr_we)       sscr_nxt = sscr_wdata; // RL15
         if (wr_cwp_en)     cwp_nxt  = (wr_cwp < 3'(NWIN)) ? wr_cwp : cwp_r;
         if (wr_psr_user)   s_nxt    = 1'b0; // RL3 RL23
      end
      if (y_we) y_nxt = y_wdata; // RL14
      if ((op_priv || wim_we || single_vec_we || sscr_we || wr_cwp_en || wr_psr_user) && !s_r)
         do_trap = 1'b1; // RL1 RL14
      if (acc_req && !acc_ok) do_trap = 1'b1;
      case (op)
         PWR_OP_SAVE: begin
            if (wim_r[cwp_dec]) do_trap = 1'b1; // RL13
            else cwp_nxt = cwp_dec; // RL11
         end
         PWR_OP_RESTORE: begin
            if (wim_r[cwp_inc]) do_trap = 1'b1; // RL13
            else cwp_nxt = cwp_inc; // RL11
         end
         PWR_OP_TRAP: do_trap = 1'b1;
         PWR_OP_TRAP_RETURN_INSTR: begin
            if (!s_r) do_trap = 1'b1;
            else begin
               s_nxt   = ps_r; // RL24
               cwp_nxt = cwp_inc;
            end
         end
         default: ;
      endcase
      if (irq) do_trap = 1'b1;
      if (do_trap) begin
         // new window even if masked; handler copes with overflow
         ps_nxt  = s_r;
         s_nxt   = 1'b1; // RL3
         cwp_nxt = cwp_dec; // RL12
         tgt_nxt = sv_r ? `PWR_TRAP_SINGLE : `PWR_TRAP_TBL_BASE; // RL16
      end
      trap_nxt = do_trap;
   end

   // register file and read port; window move never copies data
   always_comb begin
      rdata_nxt = rf_r[rf_ridx]; // RL10
   end
   always_ff @(posedge ref_clk) begin
      if (rf_we && rf_waddr != 5'd0) rf_r[rf_widx] <= rf_wdata; // RL11
   end

   // bus side: access, chip selects, wait states, same page
   always_comb begin
      logic [3:0] wsel;
      wsel      = 4'd0;
      start_nxt = 1'b0;
      bwr_nxt   = bwr_r;
      bw_nxt    = bw_r;
      bsp_nxt   = bsp_r;
      badr_nxt  = badr_r;
      rdy_nxt   = 1'b0;
      cs_nxt    = cs_r;
      sp_nxt    = sp_r;
      prev_nxt  = prev_r;
      bst_nxt   = bst_r;
      wcnt_nxt  = wcnt_r;
      case (bst_r)
         PWR_BUS_IDLE: begin
            cs_nxt = 6'h3F;
            if (acc_req && acc_is_mem && acc_ok) begin // RL6
               start_nxt = 1'b1;
               bwr_nxt   = acc_write;
               bw_nxt    = acc_width; // RL6
               bsp_nxt   = acc_space; // RL4
               badr_nxt  = acc_addr; // RL4
               if (sscr_r[`PWR_SSCR_CS]) begin // RL22
                  cs_nxt[0] = !(acc_space == `PWR_ASI_SINSTR &&
                                (acc_addr & `PWR_CS0_MASK) == 26'h0000000); // RL19
                  cs_nxt[5:1] = ~cs_hit; // RL18
               end
               if (sscr_r[`PWR_SSCR_SAMEPG]) // RL22
                  sp_nxt = !((({acc_space, acc_addr} ^ prev_r) & samepg_mask) == '0); // RL17
               else
                  sp_nxt = 1'b1;
               prev_nxt = {acc_space, acc_addr};
               if (cs_hit[1] || cs_hit[2] || cs_hit[3]) begin
                  if (cs_hit[1]) wsel = wait_counts[3:0];
                  else if (cs_hit[2]) wsel = wait_counts[7:4];
                  else wsel = wait_counts[11:8];
               end
               if (sscr_r[`PWR_SSCR_WAIT] && wsel != 4'd0) begin // RL22
                  wcnt_nxt = wsel;
                  bst_nxt  = PWR_BUS_WAIT;
               end else if (sscr_r[`PWR_SSCR_WAIT]) begin
                  rdy_nxt = 1'b1; // RL20
               end
            end
         end
         PWR_BUS_WAIT: begin
            wcnt_nxt = wcnt_r - 4'd1;
            if (wcnt_r == 4'd1) begin
               rdy_nxt = 1'b1; // RL20
               bst_nxt = PWR_BUS_IDLE;
            end
         end
         default: bst_nxt = PWR_BUS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s_r     <= 1'b1; // RL2
         ps_r    <= 1'b1;
         cwp_r   <= 3'd0;
         wim_r   <= '0;
         sv_r    <= 1'b0;
         sscr_r  <= 4'h0;
         trap_r  <= 1'b0;
         tgt_r   <= '0;
         y_r     <= '0;
         rdata_r <= '0;
         start_r <= 1'b0;
         bwr_r   <= 1'b0;
         bw_r    <= 2'h0;
         bsp_r   <= 4'h0;
         badr_r  <= '0;
         rdy_r   <= 1'b0;
         cs_r    <= 6'h3F;
         sp_r    <= 1'b1;
         prev_r  <= '0;
         bst_r   <= PWR_BUS_IDLE;
         wcnt_r  <= 4'h0;
      end else begin
         s_r     <= s_nxt;
         ps_r    <= ps_nxt;
         cwp_r   <= cwp_nxt;
         wim_r   <= wim_nxt;
         sv_r    <= sv_nxt;
         sscr_r  <= sscr_nxt;
         trap_r  <= trap_nxt;
         tgt_r   <= tgt_nxt;
         y_r     <= y_nxt;
         rdata_r <= rdata_nxt;
         start_r <= start_nxt;
         bwr_r   <= bwr_nxt;
         bw_r    <= bw_nxt;
         bsp_r   <= bsp_nxt;
         badr_r  <= badr_nxt;
         rdy_r   <= rdy_nxt;
         cs_r    <= cs_nxt;
         sp_r    <= sp_nxt;
         prev_r  <= prev_nxt;
         bst_r   <= bst_nxt;
         wcnt_r  <= wcnt_nxt;
      end
   end

   assign supervisor             = s_r;
   assign current_window_pointer = cwp_r;
   assign window_invalid_mask    = wim_r;
   assign trap_taken             = trap_r;
   assign trap_target            = tgt_r;
   assign rf_rdata               = rdata_r;
   assign y_reg                  = y_r;
   assign bus_start              = start_r;
   assign bus_write              = bwr_r;
   assign bus_width              = bw_r;
   assign bus_space              = bsp_r;
   assign bus_addr               = badr_r;
   assign bus_ready              = rdy_r;
   assign chip_sel_n             = cs_r;
   assign same_page_n            = sp_r;
endmodule

// ==== verilog/pwr_defs.svh ====
/*
 constants for the privilege/window register model.
 assumes inclusion by bare name from design files.
*/
`ifndef PWR_DEFS_SVH
`define PWR_DEFS_SVH
`define PWR_XLEN          32
`define PWR_NWIN          6
`define PWR_NGLOB         8
`define PWR_WIN_REGS      24
`define PWR_NPHYS         104
`define PWR_CWP_W         3
`define PWR_ASI_W         4
`define PWR_ADR_W         26
`define PWR_NCS           6
`define PWR_NWAIT         3
`define PWR_RSTADDR       5
`define PWR_ASI_UINSTR    4'h8
`define PWR_ASI_SINSTR    4'h9
`define PWR_ASI_UDATA     4'hA
`define PWR_ASI_SDATA     4'hB
`define PWR_CS0_MASK      26'h3F00000
`define PWR_SSCR_SAMEPG   0
`define PWR_SSCR_CS       1
`define PWR_SSCR_WAIT     2
`define PWR_SSCR_TIMER    3
`define PWR_TRAP_TBL_BASE 32'h00000000
`define PWR_TRAP_SINGLE   32'h00000000
`endif

// ==== verilog/pwr_pkg.sv ====
/*
 types for the privilege/window register model.
 assumes pwr_defs.svh is compiled alongside.
*/
package pwr_pkg;
   typedef enum logic [2:0] {
      PWR_OP_NONE,
      PWR_OP_SAVE,
      PWR_OP_RESTORE,
      PWR_OP_TRAP,
      PWR_OP_TRAP_RETURN_INSTR
   } pwr_op_t;
   typedef enum logic [1:0] {
      PWR_WIDTH_BYTE,
      PWR_WIDTH_HALF,
      PWR_WIDTH_WORD,
      PWR_WIDTH_DBL
   } pwr_width_t;
   typedef enum {
      PWR_BUS_IDLE,
      PWR_BUS_WAIT
   } pwr_bus_st_t;
endpackage

// ==== verilog/pwr_cs_if.sv ====
/*
 interface carrying one access address to the chip-select comparators.
 assumes one driver (core) and any number of comparators.
*/
`timescale 1ns/100ps
interface pwr_cs_if;
   logic [25:0] addr;
   logic [3:0]  space;
   logic        valid;
   modport src (output addr, output space, output valid);
   modport dst (input addr, input space, input valid);
endinterface

// ==== verilog/pwr_cs_cmp.sv ====
/*
 one masked address range comparator feeding a chip select.
 assumes range and mask come from registers on the same clock.
*/
`timescale 1ns/100ps
module pwr_cs_cmp
   import pwr_pkg::*;
#(
   parameter int ADR_W = 26
) (
   pwr_cs_if.dst           acc,
   input  wire logic [ADR_W-1:0] range_val,
   input  wire logic [ADR_W-1:0] range_mask,
   output      logic             hit
);
   // mask bit set means don't care
   assign hit = acc.valid && (((acc.addr ^ range_val) & ~range_mask) == '0); // RL18
endmodule

// ==== verilog/pwr_timer.sv ====
/*
 reloading up-counter timer.
 assumes enable and preload registered on ref_clk.
*/
`timescale 1ns/100ps
`include "pwr_defs.svh"
module pwr_timer
   import pwr_pkg::*;
#(
   parameter int W = 32
) (
   input  wire logic         ref_clk,
   input  wire logic         reset_n,
   input  wire logic         enable,
   input  wire logic [W-1:0] preload,
   output      logic [W-1:0] count,
   output      logic         ovf
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;
   logic         ovf_r;
   logic         ovf_nxt;
   always_comb begin
      count_nxt = count_r;
      ovf_nxt   = 1'b0;
      if (enable) begin
         if (count_r == '1) begin
            count_nxt = preload; // RL21
            ovf_nxt   = 1'b1;
         end else begin
            count_nxt = count_r + 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         count_r <= '0;
         ovf_r   <= 1'b0;
      end else begin
         count_r <= count_nxt;
         ovf_r   <= ovf_nxt;
      end
   end
   assign count = count_r;
   assign ovf   = ovf_r;
endmodule

// ==== test/pwr_core_assertions.sv ====
/*
 port-level assertions for pwr_core: privilege, windows, access, timer.
 assumes a bind from the testbench top file; sees core ports only.
*/
`timescale 1ns/100ps
module pwr_core_chk
   import pwr_pkg::*;
#(
   parameter int NWIN = 6,
   parameter int XLEN = 32
) (
   input wire logic            ref_clk,
   input wire logic            reset_n,
   input wire pwr_op_t         op,
   input wire logic            op_priv,
   input wire logic            irq,
   input wire logic            wr_cwp_en,
   input wire logic            wim_we,
   input wire logic            acc_req,
   input wire logic            acc_is_mem,
   input wire logic [3:0]      acc_space,
   input wire logic [XLEN-1:0] timer_preload,
   input wire logic            supervisor,
   input wire logic [2:0]      current_window_pointer,
   input wire logic [NWIN-1:0] window_invalid_mask,
   input wire logic            trap_taken,
   input wire logic            bus_start,
   input wire logic [XLEN-1:0] timer_count,
   input wire logic            timer_ovf
);
   logic       mreq_r;
   logic       mreq_nxt;
   logic [2:0] dec_w;
   logic [2:0] inc_w;
   logic       quiet;

   // modulo-six neighbours; codes 6 and 7 are never windows
   always_comb begin
      dec_w    = (current_window_pointer == 3'h0) ? 3'h5 : current_window_pointer - 3'h1;
      inc_w    = (current_window_pointer == 3'h5) ? 3'h0 : current_window_pointer + 3'h1;
      quiet    = !irq && !op_priv && !acc_req && !wim_we && !wr_cwp_en;
      mreq_nxt = acc_req && acc_is_mem;
   end

   always_ff @(posedge ref_clk) begin
      mreq_r <= mreq_nxt;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_trap_super;
      trap_taken && supervisor;
   endsequence

   a_reset_super: assert property ($rose(reset_n) |-> supervisor && current_window_pointer == 3'h0)
      else $error("state after reset wrong");
   a_cwp_range: assert property (current_window_pointer < 3'h6)
      else $error("window pointer out of range");
   a_save_dec: assert property (op == PWR_OP_SAVE && quiet && !window_invalid_mask[dec_w]
      |=> current_window_pointer == $past(dec_w)) else $error("save did not step down");
   a_restore_inc: assert property (op == PWR_OP_RESTORE && quiet && !window_invalid_mask[inc_w]
      |=> current_window_pointer == $past(inc_w)) else $error("restore did not step up");
   a_mask_trap: assert property (op == PWR_OP_SAVE && quiet && window_invalid_mask[dec_w] |=> trap_taken)
      else $error("masked window without trap");
   a_irq_window: assert property (irq && op == PWR_OP_NONE && !op_priv && !acc_req
      && !window_invalid_mask[dec_w] |=> s_trap_super ##0 current_window_pointer == $past(dec_w))
      else $error("interrupt entry wrong");
   a_priv_trap: assert property (!supervisor && op_priv && !irq |=> s_trap_super)
      else $error("privileged op not trapped");
   a_enter_super: assert property ($rose(supervisor) && $past(reset_n) |-> trap_taken)
      else $error("supervisor entered without trap");
   a_space_guard: assert property (!supervisor && acc_req && acc_is_mem && acc_space != 4'h8
      && acc_space != 4'hA |=> trap_taken && !bus_start) else $error("user reached guarded space");
   a_bus_cause: assert property (bus_start |-> mreq_r)
      else $error("bus start without memory request");
   a_timer_reload: assert property (timer_ovf |-> timer_count == timer_preload)
      else $error("timer not reloaded");
endmodule

// ==== test/testbench.sv ====
/*
 self-checking bench for pwr_core: windows, privilege, spaces, bus, timer.
 assumes pwr_pkg and the checker file are compiled before this file.
*/
`timescale 1ns/100ps
module testbench
   import pwr_pkg::*;
;
   logic         ref_clk, reset_n, op_priv, irq, wr_psr_user, wr_cwp_en, wim_we, single_vec_wdata;
   logic         single_vec_we, rf_we, y_we, acc_req, acc_is_mem, acc_write, sscr_we;
   logic         supervisor, trap_taken, bus_start, bus_write, bus_ready, same_page_n, timer_ovf;
   logic [1:0]   bus_width;
   logic [2:0]   wr_cwp, current_window_pointer;
   logic [3:0]   acc_space, sscr_wdata, bus_space;
   logic [4:0]   rf_waddr, rf_raddr;
   logic [5:0]   wim_wdata, window_invalid_mask, chip_sel_n;
   logic [11:0]  wait_counts;
   logic [25:0]  acc_addr, bus_addr;
   logic [29:0]  samepg_mask;
   logic [31:0]  rf_wdata, y_wdata, timer_preload, trap_target, rf_rdata, y_reg, timer_count, tmp;
   logic [129:0] range_vals;
   logic [155:0] range_masks;
   pwr_op_t      op;
   pwr_width_t   acc_width;
   int           error_cnt = 0, num_checks = 0, n;

   pwr_core dut_u (.ref_clk, .reset_n, .op, .op_priv, .irq, .wr_psr_user, .wr_cwp, .wr_cwp_en,
      .wim_wdata, .wim_we, .single_vec_wdata, .single_vec_we, .rf_we, .rf_waddr, .rf_wdata, .rf_raddr,
      .y_we, .y_wdata, .acc_req, .acc_is_mem, .acc_write, .acc_width, .acc_space, .acc_addr, .sscr_wdata,
      .sscr_we, .samepg_mask, .range_vals, .range_masks, .wait_counts, .timer_preload, .supervisor,
      .current_window_pointer, .window_invalid_mask, .trap_taken, .trap_target, .rf_rdata, .y_reg,
      .bus_start, .bus_write, .bus_width, .bus_space, .bus_addr, .bus_ready, .chip_sel_n, .same_page_n,
      .timer_count, .timer_ovf);

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic tick();
      @(posedge ref_clk);
      #2;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // window pointer back to zero so each scenario starts alike
   task automatic home();
      wr_cwp_en = 1'b1;
      wr_cwp = 3'h0;
      tick();
      wr_cwp_en = 1'b0;
   endtask

   task automatic acc(input logic [3:0] sp, input logic [25:0] ad, input pwr_width_t w,
                      input logic [5:0] cs, input int wt, input logic spn);
      {acc_space, acc_addr, acc_width, acc_write, acc_req} = {sp, ad, w, w[0], 1'b1};
      tick();
      acc_req = 1'b0;
      chk(bus_start, 1'b1);
      chk({bus_width, bus_space, bus_addr}, {w, sp, ad});
      chk(bus_write, w[0]);
      chk(chip_sel_n, cs);
      chk(same_page_n, spn);
      n = 0;
      while (bus_ready !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
      chk(n, wt);
      tick();
   endtask

   task automatic t_windows();
      {rf_we, rf_waddr, rf_wdata} = {1'b1, 5'd1, 32'h600D0001};
      tick();
      {rf_waddr, rf_wdata} = {5'd8, 32'h0000BEEF};
      tick();
      rf_we = 1'b0;
      op = PWR_OP_SAVE;
      tick();
      chk(current_window_pointer, 3'h5);
      rf_raddr = 5'd24;
      tick();
      chk(rf_rdata, 32'h0000BEEF);
      chk(current_window_pointer, 3'h4);
      rf_raddr = 5'd1;
      op = PWR_OP_RESTORE;
      tick();
      chk(rf_rdata, 32'h600D0001);
      tick();
      op = PWR_OP_NONE;
      chk(current_window_pointer, 3'h0);
   endtask

   task automatic t_traps();
      {wim_we, wim_wdata} = {1'b1, 6'h20};
      tick();
      wim_we = 1'b0;
      op = PWR_OP_SAVE;
      tick();
      op = PWR_OP_NONE;
      chk(trap_taken, 1'b1);
      {wim_we, wim_wdata} = {1'b1, 6'h00};
      tick();
      wim_we = 1'b0;
      home();
      irq = 1'b1;
      tick();
      irq = 1'b0;
      chk({trap_taken, current_window_pointer}, 4'hD);
      chk(trap_target, 32'h00000000);
      home();
   endtask

   task automatic t_user();
      wr_psr_user = 1'b1;
      tick();
      wr_psr_user = 1'b0;
      chk(supervisor, 1'b0);
      {y_we, y_wdata} = {1'b1, 32'h1234ABCD};
      tick();
      y_we = 1'b0;
      chk(trap_taken, 1'b0);
      chk(y_reg, 32'h1234ABCD);
      {wim_we, wim_wdata} = {1'b1, 6'h01};
      tick();
      wim_we = 1'b0;
      chk({trap_taken, window_invalid_mask}, 7'h40);
      op = PWR_OP_TRAP_RETURN_INSTR;
      tick();
      op = PWR_OP_NONE;
      chk({supervisor, current_window_pointer}, 4'h0);
      op_priv = 1'b1;
      tick();
      op_priv = 1'b0;
      chk({trap_taken, supervisor}, 2'b11);
      home();
   endtask

   task automatic t_spaces();
      {sscr_we, sscr_wdata} = {1'b1, 4'h4};
      tick();
      sscr_we = 1'b0;
      wr_psr_user = 1'b1;
      tick();
      wr_psr_user = 1'b0;
      // odd codes are the supervisor spaces; each trap is undone by a return
      for (int i = 0; i < 4; i++) begin
         {acc_space, acc_addr, acc_req, acc_is_mem} = {4'h8 + i[3:0], 26'h0, 2'b11};
         tick();
         acc_req = 1'b0;
         chk({trap_taken, bus_start}, {i[0], !i[0]});
         op = i[0] ? PWR_OP_TRAP_RETURN_INSTR : PWR_OP_NONE;
         tick();
         op = PWR_OP_NONE;
         tick();
      end
      op_priv = 1'b1;
      tick();
      op_priv = 1'b0;
      home();
   endtask

   task automatic t_bus();
      {sscr_we, sscr_wdata} = {1'b1, 4'h7};
      tick();
      sscr_we = 1'b0;
      acc(4'hB, 26'h0100123, PWR_WIDTH_BYTE, 6'h3D, 3, 1'b1);
      acc(4'hA, 26'h0100456, PWR_WIDTH_HALF, 6'h3D, 3, 1'b0);
      acc(4'h9, 26'h0000000, PWR_WIDTH_WORD, 6'h3E, 0, 1'b1);
      acc(4'hB, 26'h2000000, PWR_WIDTH_DBL, 6'h3F, 0, 1'b1);
      {sscr_we, sscr_wdata} = {1'b1, 4'h4};
      tick();
      sscr_we = 1'b0;
      acc(4'hB, 26'h0100123, PWR_WIDTH_WORD, 6'h3F, 3, 1'b1);
   endtask

   task automatic t_timer();
      tmp = timer_count;
      tick();
      tick();
      chk(timer_count, tmp);
      {sscr_we, sscr_wdata} = {1'b1, 4'h8};
      tick();
      sscr_we = 1'b0;
      // one spare edge: the enable may pass a register first
      tick();
      tmp = timer_count;
      tick();
      tick();
      chk(timer_count, tmp + 32'h2);
   endtask

   initial begin
      reset_n = 1'b0;
      op = PWR_OP_NONE;
      acc_width = PWR_WIDTH_BYTE;
      {op_priv, irq, wr_psr_user, wr_cwp_en, wim_we, single_vec_wdata, single_vec_we, rf_we, y_we} = '0;
      {acc_req, acc_is_mem, acc_write, sscr_we, wr_cwp, wim_wdata, rf_waddr, rf_raddr} = '0;
      {rf_wdata, y_wdata, acc_space, sscr_wdata, acc_addr} = '0;
      samepg_mask = 30'h03FF0000;
      range_vals = {{4{26'h3FFFFFF}}, 26'h0100000};
      range_masks = {{4{26'h0000000}}, 26'h00FFFFF, 26'h0000000};
      wait_counts = 12'h003;
      timer_preload = 32'hFFFFFFF0;
      repeat (2) @(posedge ref_clk);
      #2 reset_n = 1'b1;
      chk({supervisor, current_window_pointer, window_invalid_mask}, 10'h200);
      chk({chip_sel_n, same_page_n}, 7'h7F);
      t_windows();
      t_traps();
      t_user();
      t_spaces();
      t_bus();
      t_timer();
      results();
   end

   // whole run is under a hundred cycles; this is far beyond it
   initial begin
      #100000;
      error_cnt++;
      results();
   end
endmodule

bind pwr_core pwr_core_chk #(.NWIN(NWIN), .XLEN(XLEN)) chk_u (.ref_clk, .reset_n, .op, .op_priv, .irq,
   .wr_cwp_en, .wim_we, .acc_req, .acc_is_mem, .acc_space, .timer_preload, .supervisor,
   .current_window_pointer, .window_invalid_mask, .trap_taken, .bus_start, .timer_count, .timer_ovf);
